/* File: logic/prio_pkg.sv */
// Package for the interrupt priority field block.
// Assumes one 10 MHz clock and a 32-bit Avalon-MM register bus.
package prio_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NSRC = 4;
  localparam int PRIO_W = 3;
  localparam int SRC_W = 2;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_DMA_PRIO = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_AUDIO_PRIO = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PRESENT = 8'h10;

  // Source indices
  localparam logic [SRC_W-1:0] SRC_CHAN_SIX = 2'h0;
  localparam logic [SRC_W-1:0] SRC_CHAN_SEVEN = 2'h1;
  localparam logic [SRC_W-1:0] SRC_AUDIO_RIGHT = 2'h2;
  localparam logic [SRC_W-1:0] SRC_AUDIO_LEFT = 2'h3;

  // Field positions inside the priority registers
  localparam int CHAN_SIX_LSB = 0;
  localparam int CHAN_SEVEN_LSB = 4;
  localparam int AUDIO_RIGHT_LSB = 8;
  localparam int AUDIO_LEFT_LSB = 12;

  // Present register layout
  localparam int PRES_LEVEL_LSB = 0;
  localparam int PRES_SRC_LSB = 4;
  localparam int PRES_VALID_BIT = 8;

  // Priority codes
  localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
  localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;

  localparam logic [NSRC-1:0] EVT_ZERO = 4'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [DATA_W-1:0] writedata;
    logic [3:0] byteenable;
  } av_req_t;

  typedef struct packed {
    logic valid;
    logic [SRC_W-1:0] src;
    logic [PRIO_W-1:0] level;
  } present_t;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_t;

endpackage

/* File: logic/sync_two_ff.sv */
// Two-flop synchroniser for one level.
// Assumes the destination clock and an active-low asynchronous reset.
`timescale 1ns/10ps
module sync_two_ff (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Level
  input wire logic d_in,
  output logic q_out
);

  logic stage_reg;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stage_reg <= 1'b0;
      q_out <= 1'b0;
    end else begin
      stage_reg <= d_in;
      q_out <= stage_reg;
    end
  end

endmodule

/* File: logic/prio_field.sv */
// One 3-bit read/write priority field.
// Assumes a synchronous write strobe from the register bus.
`timescale 1ns/10ps
module prio_field
  import prio_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Write port
  input wire logic wr_in,
  input wire logic [prio_pkg::PRIO_W-1:0] data_in,
  // Field value
  output logic [prio_pkg::PRIO_W-1:0] prio_out
);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prio_out <= PRIO_RESET;
    end else if (wr_in) begin
      prio_out <= data_in;
    end
  end

endmodule

/* File: logic/prio_ctrl.sv */
// Priority fields for two transfer-complete and two audio sources.
// Assumes Avalon-MM master on core_clk_in and same-clock event pulses.
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////
module prio_ctrl
  import prio_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // Avalon-MM slave
  input wire prio_pkg::av_req_t av_req_in,
  output logic [prio_pkg::DATA_W-1:0] av_readdata_out,
  output logic av_waitrequest_out,
  // Source events and variant strap
  input wire logic chan_six_done_in,
  input wire logic chan_seven_done_in,
  input wire logic audio_right_in,
  input wire logic audio_left_in,
  input wire logic audio_fitted_in,
  // Presented interrupt
  output prio_pkg::present_t present_out,
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////
  // Reset and strap synchronisers

  logic rst_sync_n;
  logic audio_fitted;

  sync_two_ff u_rst_sync (
    .clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .d_in(1'b1),
    .q_out(rst_sync_n)
  );

  sync_two_ff u_fit_sync (
    .clk_in(core_clk_in),
    .rstn_in(rst_sync_n),
    .d_in(audio_fitted_in),
    .q_out(audio_fitted)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake

  bus_state_t bus_state_reg;
  bus_state_t bus_state_next;
  logic req_active;
  logic commit_wr;

  assign req_active = av_req_in.read | av_req_in.write;

  always_comb begin
    case (bus_state_reg)
      BUS_IDLE: begin
        bus_state_next = req_active ? BUS_ANSWER : BUS_IDLE;
      end
      BUS_ANSWER: begin
        bus_state_next = BUS_IDLE;
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  assign av_waitrequest_out = req_active & (bus_state_reg != BUS_ANSWER);
  assign commit_wr = av_req_in.write & (bus_state_reg == BUS_ANSWER);

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  logic sel_dma;
  logic sel_audio;
  logic sel_status;
  logic sel_mask;
  logic sel_present;

  assign sel_dma = av_req_in.address == OFS_DMA_PRIO;
  assign sel_audio = av_req_in.address == OFS_AUDIO_PRIO;
  assign sel_status = av_req_in.address == OFS_STATUS;
  assign sel_mask = av_req_in.address == OFS_MASK;
  assign sel_present = av_req_in.address == OFS_PRESENT;

  ////////////////////////////////////////////////////////////////////////
  // Priority fields

  localparam int FIELD_LSB [NSRC] = '{
    CHAN_SIX_LSB, CHAN_SEVEN_LSB, AUDIO_RIGHT_LSB, AUDIO_LEFT_LSB
  };

  logic [PRIO_W-1:0] prio_field [NSRC];
  logic [PRIO_W-1:0] prio_eff [NSRC];
  logic [NSRC-1:0] field_wr;
  logic [NSRC-1:0] field_is_audio;

  assign field_is_audio = {1'b1, 1'b1, 1'b0, 1'b0};

  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_field
      assign field_wr[gi] = commit_wr
        & (field_is_audio[gi] ? sel_audio : sel_dma)
        & av_req_in.byteenable[FIELD_LSB[gi] / 8];

      prio_field u_field (
        .clk_in(core_clk_in),
        .rstn_in(rst_sync_n),
        .wr_in(field_wr[gi]),
        .data_in(av_req_in.writedata[FIELD_LSB[gi] +: PRIO_W]),
        .prio_out(prio_field[gi])
      );

      // Audio sources are forced off on a variant without the converter
      assign prio_eff[gi] = (field_is_audio[gi] & ~audio_fitted)
        ? PRIO_OFF : prio_field[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Event status and mask

  logic [NSRC-1:0] event_in;
  logic [NSRC-1:0] status_reg;
  logic [NSRC-1:0] mask_reg;
  logic [NSRC-1:0] status_clr;

  assign event_in = {audio_left_in, audio_right_in, chan_seven_done_in, chan_six_done_in};

  assign status_clr = (commit_wr & sel_status & av_req_in.byteenable[0])
    ? av_req_in.writedata[NSRC-1:0] : EVT_ZERO;

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      status_reg <= EVT_ZERO;
    end else begin
      status_reg <= (status_reg & ~status_clr) | event_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mask_reg <= EVT_ZERO;
    end else if (commit_wr & sel_mask & av_req_in.byteenable[0]) begin
      mask_reg <= av_req_in.writedata[NSRC-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Arbitration

  logic [NSRC-1:0] candidate;
  logic cand_found;
  logic [SRC_W-1:0] cand_src;
  logic [PRIO_W-1:0] cand_level;

  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_cand
      assign candidate[gi] = status_reg[gi] & mask_reg[gi]
        & (prio_eff[gi] != PRIO_OFF);
    end
  endgenerate

  // Larger code wins; on a tie the lower source index stays
  always_comb begin
    cand_found = 1'b0;
    cand_src = SRC_CHAN_SIX;
    cand_level = PRIO_OFF;
    for (int i = 0; i < NSRC; i++) begin
      if (candidate[i] && (prio_eff[i] > cand_level)) begin
        cand_found = 1'b1;
        cand_src = SRC_W'(i);
        cand_level = prio_eff[i];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      present_out <= '0;
    end else begin
      present_out.valid <= cand_found;
      present_out.src <= cand_src;
      present_out.level <= cand_level;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |candidate;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data

  logic [DATA_W-1:0] rd_word;

  always_comb begin
    rd_word = DATA_ZERO;
    if (sel_dma) begin
      rd_word[CHAN_SEVEN_LSB +: PRIO_W] = prio_field[SRC_CHAN_SEVEN];
      rd_word[CHAN_SIX_LSB +: PRIO_W] = prio_field[SRC_CHAN_SIX];
    end else if (sel_audio) begin
      rd_word[AUDIO_LEFT_LSB +: PRIO_W] = prio_field[SRC_AUDIO_LEFT];
      rd_word[AUDIO_RIGHT_LSB +: PRIO_W] = prio_field[SRC_AUDIO_RIGHT];
      // Low byte left at zero
      rd_word[7:0] = 8'h00;
    end else if (sel_status) begin
      rd_word[NSRC-1:0] = status_reg;
    end else if (sel_mask) begin
      rd_word[NSRC-1:0] = mask_reg;
    end else if (sel_present) begin
      rd_word[PRES_LEVEL_LSB +: PRIO_W] = present_out.level;
      rd_word[PRES_SRC_LSB +: SRC_W] = present_out.src;
      rd_word[PRES_VALID_BIT] = present_out.valid;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      av_readdata_out <= DATA_ZERO;
    end else if (av_req_in.read & (bus_state_reg == BUS_IDLE)) begin
      av_readdata_out <= rd_word;
    end
  end

endmodule

/* File: verification/prio_ctrl_properties.sv */
// Port checker for the priority field block.
// Assumes binding to prio_ctrl on its single clock.
`timescale 1ns/10ps
module prio_ctrl_checker (
  // Clock, reset and bus
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire prio_pkg::av_req_t av_req_in,
  input wire logic [prio_pkg::DATA_W-1:0] av_readdata_out,
  input wire logic av_waitrequest_out,
  // Strap and interrupt
  input wire logic audio_fitted_in,
  input wire prio_pkg::present_t present_out,
  input wire logic irq_out
);
  import prio_pkg::*;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  logic rd_done;
  assign rd_done = av_req_in.read && !av_waitrequest_out;
  ////////////////////////////////////////////////////////////////////////
  property p_wait_first;
    $rose(av_req_in.read || av_req_in.write) |-> av_waitrequest_out;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait cycle");
  property p_wait_one;
    (av_req_in.read || av_req_in.write) && av_waitrequest_out |=> !av_waitrequest_out;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait too long");
  property p_dma_rsvd;
    rd_done && av_req_in.address == OFS_DMA_PRIO |-> (av_readdata_out & 32'hFFFF_FF88) == DATA_ZERO;
  endproperty
  a_dma_rsvd: assert property (p_dma_rsvd) else $error("dma spare bits set");
  property p_audio_low;
    rd_done && av_req_in.address == OFS_AUDIO_PRIO |-> av_readdata_out[7:0] == 8'h00;
  endproperty
  a_audio_low: assert property (p_audio_low) else $error("audio low byte set");
  property p_audio_rsvd;
    rd_done && av_req_in.address == OFS_AUDIO_PRIO |-> (av_readdata_out & 32'hFFFF_8800) == DATA_ZERO;
  endproperty
  a_audio_rsvd: assert property (p_audio_rsvd) else $error("audio spare bits set");
  property p_off_never;
    present_out.valid |-> present_out.level != PRIO_OFF;
  endproperty
  a_off_never: assert property (p_off_never) else $error("level zero presented");
  property p_irq_present;
    irq_out == present_out.valid;
  endproperty
  a_irq_present: assert property (p_irq_present) else $error("irq and present differ");
  property p_no_audio;
    !audio_fitted_in [*5] |-> !(present_out.valid && present_out.src[1]);
  endproperty
  a_no_audio: assert property (p_no_audio) else $error("audio presented while absent");
  property p_reset_quiet;
    $rose(rstn_in) |-> (!irq_out && !present_out.valid) [*2];
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("active after reset");
endmodule
bind prio_ctrl prio_ctrl_checker u_chk (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .av_req_in(av_req_in),
  .av_readdata_out(av_readdata_out), .av_waitrequest_out(av_waitrequest_out),
  .audio_fitted_in(audio_fitted_in), .present_out(present_out), .irq_out(irq_out));

/* File: verification/dma_dac_irq_priority_fields_tb_top.sv */
// Self-checking bench for the priority field block.
// Assumes prio_ctrl and its checker are compiled alongside.
`timescale 1ns/10ps
module dma_dac_irq_priority_fields_tb_top;
  import prio_pkg::*;
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  av_req_t req = '0;
  logic [DATA_W-1:0] rdata;
  logic wreq;
  logic [3:0] ev = 4'h0;
  logic fit = 1'b1;
  present_t pres;
  logic irq;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] q;
  logic [31:0] exp_v;
  logic [11:0] pr;
  logic [3:0] pend;
  logic [3:0] be = 4'hF;
  always #50 core_clk_in = ~core_clk_in;
  prio_ctrl DUT (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .av_req_in(req), .av_readdata_out(rdata),
    .av_waitrequest_out(wreq), .chan_six_done_in(ev[0]), .chan_seven_done_in(ev[1]), .audio_right_in(ev[2]),
    .audio_left_in(ev[3]), .audio_fitted_in(fit), .present_out(pres), .irq_out(irq));
  ////////////////////////////////////////////////////////////////////////
  task test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge; data taken at that edge
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    req <= '{address: a, read: !wr, write: wr, writedata: d, byteenable: be};
    do @(posedge core_clk_in); while (wreq !== 1'b0);
    q = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, DATA_ZERO);
    check(q, e);
  endtask
  task rst(input int n);
    rstn_in <= 1'b0;
    repeat (n) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
  endtask
  // Winner among pending sources: highest level, lower index on a tie
  function automatic logic [31:0] exp_pres(input logic [11:0] p, input logic [3:0] pd, input logic f);
    logic [2:0] best;
    logic [2:0] lv;
    logic [1:0] s;
    logic v;
    best = 3'h0;
    s = 2'h0;
    v = 1'b0;
    for (int k = 0; k < 4; k++) begin
      lv = (k >= 2 && !f) ? 3'h0 : p[3*k+:3];
      if (pd[k] && lv > best) begin
        best = lv;
        s = k[1:0];
        v = 1'b1;
      end
    end
    return {23'h0, v, 2'h0, s, 1'b0, best};
  endfunction
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h98644C00));
    rst(16);
    rd_chk(OFS_DMA_PRIO, 32'h0000_0044);
    rd_chk(OFS_AUDIO_PRIO, 32'h0000_4400);
    rd_chk(8'h14, DATA_ZERO);
    for (int i = 0; i < 8; i++) begin
      exp_v = (i == 0) ? 32'hFFFF_FFFF : $urandom();
      bus(1'b1, OFS_DMA_PRIO, exp_v);
      rd_chk(OFS_DMA_PRIO, exp_v & 32'h0000_0077);
      bus(1'b1, OFS_AUDIO_PRIO, ~exp_v);
      rd_chk(OFS_AUDIO_PRIO, ~exp_v & 32'h0000_7700);
    end
    // Writes with the field lanes disabled leave both registers unchanged
    be = 4'hC;
    bus(1'b1, OFS_DMA_PRIO, DATA_ZERO);
    bus(1'b1, OFS_AUDIO_PRIO, DATA_ZERO);
    be = 4'hF;
    rd_chk(OFS_DMA_PRIO, exp_v & 32'h0000_0077);
    rd_chk(OFS_AUDIO_PRIO, ~exp_v & 32'h0000_7700);
    bus(1'b1, OFS_MASK, 32'h0000_000F);
    for (int i = 0; i < 16; i++) begin
      pr = (i == 0) ? 12'h000 : 12'($urandom());
      pend = (i < 2) ? 4'hF : 4'($urandom());
      fit <= (i == 1) ? 1'b0 : 1'($urandom());
      bus(1'b1, OFS_DMA_PRIO, {25'h0, pr[5:3], 1'b0, pr[2:0]});
      bus(1'b1, OFS_AUDIO_PRIO, {17'h0, pr[11:9], 1'b0, pr[8:6], 8'h00});
      bus(1'b1, OFS_STATUS, 32'h0000_000F);
      ev <= pend;
      @(posedge core_clk_in);
      ev <= 4'h0;
      repeat (2) @(posedge core_clk_in);
      exp_v = exp_pres(pr, pend, fit);
      rd_chk(OFS_STATUS, {28'h0, pend});
      rd_chk(OFS_PRESENT, exp_v);
      check({23'h0, pres.valid, 2'h0, pres.src, 1'b0, pres.level}, exp_v);
      check({31'h0, irq}, {31'h0, exp_v[8]});
      bus(1'b1, OFS_MASK, DATA_ZERO);
      repeat (2) @(posedge core_clk_in);
      check({31'h0, irq}, DATA_ZERO);
      bus(1'b1, OFS_MASK, 32'h0000_000F);
    end
    rst(3);
    rd_chk(OFS_DMA_PRIO, 32'h0000_0044);
    rd_chk(OFS_MASK, DATA_ZERO);
    test_done();
  end
endmodule
